//--- hw/sbf_defines.vh
/*
 * Constants for the slip-buffer event flag block: register byte offsets,
 * field positions, reset values and access masks.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef SBF_DEFINES_VH
`define SBF_DEFINES_VH

// ***************************************************************
// Register map, byte addresses on the Avalon-MM slave
// ***************************************************************
`define SBF_ADDR_W          4
`define SBF_OFS_STATUS      4'h0
`define SBF_OFS_ENABLE      4'h4
`define SBF_DATA_W          32
`define SBF_REG_W           8

// ***************************************************************
// Field positions, shared by status and enable layouts
// ***************************************************************
`define SBF_BIT_TX_OVF      7
`define SBF_BIT_TX_UNF      6
`define SBF_BIT_TX_SLIP     5
`define SBF_BIT_RX_OVF      2
`define SBF_BIT_RX_UNF      1
`define SBF_BIT_RX_SLIP     0

// ***************************************************************
// Reset values and masks
// ***************************************************************
`define SBF_STATUS_RST      8'h00
`define SBF_ENABLE_RST      8'h00
`define SBF_ENABLE_MASK     8'he7
`define SBF_ZERO8           8'h00
`define SBF_ZERO32          32'h0000_0000

// ***************************************************************
// Elastic store geometry defaults
// ***************************************************************
`define SBF_FRAME_WORDS     32
`define SBF_STORE_FRAMES    2

`endif

//--- hw/sbf_store_ctl.v
/*
 * Elastic store fill tracker with controlled frame slip.
 * Counts words written and read; a write into a full store deletes one
 * frame, a read from an empty store replays one frame.
 * Assumes write and read strobes come from logic on sys_clk.
 */
`timescale 1ns/1ps
`include "sbf_defines.vh"

module sbf_store_ctl #(
    parameter FRAME_WORDS  = `SBF_FRAME_WORDS,
    parameter STORE_FRAMES = `SBF_STORE_FRAMES,
    parameter LVL_W        = 8
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             nrst,
    // Store access strobes
    input  wire             wr_stb,
    input  wire             rd_stb,
    // Slip events as one-cycle pulses, and the fill level
    output reg              frame_delete_r,
    output reg              frame_repeat_r,
    output reg  [LVL_W-1:0] level_r
);

    // Geometry worked out at full width, then cut to the level width on
    // purpose; LVL_W must hold FRAME_WORDS * STORE_FRAMES
    localparam [31:0]      FRAME_INT = FRAME_WORDS;
    localparam [31:0]      FULL_INT  = FRAME_WORDS * STORE_FRAMES;
    localparam [LVL_W-1:0] FRAME_LVL = FRAME_INT[LVL_W-1:0];
    localparam [LVL_W-1:0] FULL_LVL  = FULL_INT[LVL_W-1:0];
    localparam [LVL_W-1:0] ONE_LVL   = {{(LVL_W-1){1'b0}}, 1'b1};
    localparam [LVL_W-1:0] ZERO_LVL  = {LVL_W{1'b0}};

    reg  [LVL_W-1:0] level_nxt;
    wire             is_full  = (level_r == FULL_LVL);
    wire             is_empty = (level_r == ZERO_LVL);
    wire             ovf      = wr_stb & ~rd_stb & is_full;
    wire             unf      = rd_stb & ~wr_stb & is_empty;

    // Next fill level; a simultaneous read and write cancel out
    always @*
    begin
        level_nxt = level_r;
        if (ovf)
            level_nxt = level_r - FRAME_LVL + ONE_LVL;
        else if (unf)
            level_nxt = level_r + FRAME_LVL - ONE_LVL;
        else if (wr_stb & ~rd_stb)
            level_nxt = level_r + ONE_LVL;
        else if (rd_stb & ~wr_stb)
            level_nxt = level_r - ONE_LVL;
    end

    // Level and slip pulses
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            level_r        <= ZERO_LVL;
            frame_delete_r <= 1'b0;
            frame_repeat_r <= 1'b0;
        end
        else
        begin
            level_r        <= level_nxt;
            frame_delete_r <= ovf;
            frame_repeat_r <= unf;
        end
    end

endmodule // sbf_store_ctl

//--- hw/sbf_top.v
/*
 * Slip-buffer event flags and interrupt enables for a framer.
 * Holds receive and transmit elastic store trackers, a sticky status
 * register cleared by read, an enable register and one interrupt output,
 * reached over an Avalon-MM slave with waitrequest.
 * Slip actions leave as one-cycle pulses toward the store datapath;
 * the fill levels stay inside the trackers.
 * Register offsets and field positions live in the shared defines
 * header; geometry defaults follow the two-frame store.
 * Assumes all strobes come from logic on sys_clk, a synchronous
 * active-low reset, and a master that holds each request until it
 * samples waitrequest low.
 */
// Local design decisions: register access over Avalon-MM and the register addresses.
// Contract
// - Rx empty read replays frame, sets bit1
// - Rx slip bit0 on underflow or overflow
// - Rx full write discards frame, records slip
// - Status flags reset zero, clear on read
// - Enable bit7 gates tx overflow interrupt
// - Enable bit6 gates tx underflow interrupt
// - Enable bit5 gates tx slip interrupt
// - Tx full write drops frame, sets flag
// - Tx empty read repeats frame, sets flag
// - Rx overflow flag at bit2, clear on read
// - Tx flags at bits 7,6,5, clear on read
// - Rx enables at bits 2,1,0, reset zero
`timescale 1ns/1ps
`include "sbf_defines.vh"

module sbf_top #(
    parameter FRAME_WORDS  = `SBF_FRAME_WORDS,
    parameter STORE_FRAMES = `SBF_STORE_FRAMES,
    parameter LVL_W        = 8
) (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      nrst,
    // Avalon-MM slave
    input  wire [`SBF_ADDR_W-1:0]    avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [`SBF_DATA_W-1:0]    avs_writedata,
    output reg  [`SBF_DATA_W-1:0]    avs_readdata,
    output reg                       avs_waitrequest,
    // Receive elastic store access
    input  wire                      rx_wr_stb,
    input  wire                      rx_rd_stb,
    // Transmit elastic store access
    input  wire                      tx_wr_stb,
    input  wire                      tx_rd_stb,
    // Slip actions to the store datapath
    output wire                      rx_frame_delete,
    output wire                      rx_frame_repeat,
    output wire                      tx_frame_delete,
    output wire                      tx_frame_repeat,
    // Interrupt request, level
    output reg                       irq
);

    // ***************************************************************
    // Elastic store trackers
    // ***************************************************************

    // Receive side store; its level is only needed inside the tracker
    sbf_store_ctl #(
        .FRAME_WORDS  (FRAME_WORDS),
        .STORE_FRAMES (STORE_FRAMES),
        .LVL_W        (LVL_W)
    ) u_rx_store (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .wr_stb         (rx_wr_stb),
        .rd_stb         (rx_rd_stb),
        .frame_delete_r (rx_frame_delete),
        .frame_repeat_r (rx_frame_repeat),
        .level_r        ()
    );

    // Transmit side store
    sbf_store_ctl #(
        .FRAME_WORDS  (FRAME_WORDS),
        .STORE_FRAMES (STORE_FRAMES),
        .LVL_W        (LVL_W)
    ) u_tx_store (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .wr_stb         (tx_wr_stb),
        .rd_stb         (tx_rd_stb),
        .frame_delete_r (tx_frame_delete),
        .frame_repeat_r (tx_frame_repeat),
        .level_r        ()
    );

    // ***************************************************************
    // Event vector in status layout
    // ***************************************************************

    reg [`SBF_REG_W-1:0] evt_set;

    // Status layout, shared with the enable register
    // Slip bits fire on either direction of the same store
    // Pulses are one cycle wide, so each event sets its flag once
    always @*
    begin
        evt_set                     = `SBF_ZERO8;
        evt_set[`SBF_BIT_RX_UNF]    = rx_frame_repeat;
        evt_set[`SBF_BIT_RX_SLIP]   = rx_frame_repeat | rx_frame_delete;
        evt_set[`SBF_BIT_RX_OVF]    = rx_frame_delete;
        evt_set[`SBF_BIT_TX_OVF]    = tx_frame_delete;
        evt_set[`SBF_BIT_TX_UNF]    = tx_frame_repeat;
        evt_set[`SBF_BIT_TX_SLIP]   = tx_frame_repeat | tx_frame_delete;
    end

    // ***************************************************************
    // Avalon-MM handshake
    // ***************************************************************

    // Address decode; the full offset is compared, so any other
    // offset reads zero and ignores writes
    wire       hit_stat = (avs_address == `SBF_OFS_STATUS);
    wire       hit_en   = (avs_address == `SBF_OFS_ENABLE);

    // ***************************************************************
    // Handshake state machine
    // ***************************************************************

    // One wait cycle: the request is seen, data is staged, then
    // waitrequest drops for exactly one cycle.
    localparam [1:0] BUS_IDLE = 2'b01;
    localparam [1:0] BUS_ACK  = 2'b10;

    reg  [1:0] bus_state_r;
    reg  [1:0] bus_state_nxt;
    wire       req     = avs_read | avs_write;
    wire       ack_nxt = (bus_state_nxt == BUS_ACK);
    wire       commit  = req & (bus_state_r == BUS_ACK);
    wire       wr_fire = avs_write & commit;
    wire       rd_fire = avs_read & commit;

    // Next state; a request is answered once per pass through idle,
    // and the master has dropped it by the time idle is back
    always @*
    begin
        case (bus_state_r)
            BUS_IDLE:
            begin
                bus_state_nxt = req ? BUS_ACK : BUS_IDLE;
            end
            BUS_ACK:
            begin
                bus_state_nxt = BUS_IDLE;
            end
            default:
            begin
                // Unused codes fall back to idle
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // Handshake state; waitrequest comes from a flop, high in reset
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            bus_state_r     <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            bus_state_r     <= bus_state_nxt;
            avs_waitrequest <= ~ack_nxt;
        end
    end

    // ***************************************************************
    // Status and enable registers
    // ***************************************************************

    reg  [`SBF_REG_W-1:0] status_r;
    reg  [`SBF_REG_W-1:0] status_nxt;
    reg  [`SBF_REG_W-1:0] enable_r;
    reg  [`SBF_REG_W-1:0] enable_nxt;
    reg  [`SBF_REG_W-1:0] clr_mask;

    // Clear only the bits software actually saw, so an event that lands
    // between the snapshot and the commit edge is not lost; set wins.
    // Writes to this offset are ignored: there is no write-to-clear.
    always @*
    begin
        clr_mask = `SBF_ZERO8;
        if (rd_fire & hit_stat)
            clr_mask = avs_readdata[`SBF_REG_W-1:0];
        status_nxt = (status_r & ~clr_mask) | evt_set;
    end

    // Enable register, reserved bits forced to zero
    // Bits 4 and 3 have no field, so the mask drops them on write
    always @*
    begin
        enable_nxt = enable_r;
        if (wr_fire & hit_en)
            enable_nxt = avs_writedata[`SBF_REG_W-1:0] & `SBF_ENABLE_MASK;
    end

    // Status register, all flags clear out of reset
    always @(posedge sys_clk)
    begin
        if (!nrst)
            status_r <= `SBF_STATUS_RST;
        else
            status_r <= status_nxt;
    end

    // Enable register, all sources masked out of reset
    always @(posedge sys_clk)
    begin
        if (!nrst)
            enable_r <= `SBF_ENABLE_RST;
        else
            enable_r <= enable_nxt;
    end

    // ***************************************************************
    // Read data
    // ***************************************************************

    reg [`SBF_DATA_W-1:0] rdata_nxt;

    // Unmapped addresses read zero; upper bits read zero
    always @*
    begin
        rdata_nxt = `SBF_ZERO32;
        case (avs_address)
            `SBF_OFS_STATUS:
            begin
                rdata_nxt[`SBF_REG_W-1:0] = status_r;
            end
            `SBF_OFS_ENABLE:
            begin
                rdata_nxt[`SBF_REG_W-1:0] = enable_r;
            end
            default:
            begin
                rdata_nxt = `SBF_ZERO32;
            end
        endcase
    end

    // Snapshot taken when the request is first seen and held to commit
    // Holding it keeps the clear mask equal to what the master takes
    always @(posedge sys_clk)
    begin
        if (!nrst)
            avs_readdata <= `SBF_ZERO32;
        else if (avs_read & ack_nxt)
            avs_readdata <= rdata_nxt;
    end

    // ***************************************************************
    // Named fields at next state
    // ***************************************************************

    // Status fields, sticky until read
    wire tx_store_overflow_flag_nxt  = status_nxt[`SBF_BIT_TX_OVF];
    wire tx_store_underflow_flag_nxt = status_nxt[`SBF_BIT_TX_UNF];
    wire tx_store_slip_flag_nxt      = status_nxt[`SBF_BIT_TX_SLIP];
    wire rx_store_overflow_flag_nxt  = status_nxt[`SBF_BIT_RX_OVF];
    wire rx_store_underflow_flag_nxt = status_nxt[`SBF_BIT_RX_UNF];
    wire rx_store_slip_flag_nxt      = status_nxt[`SBF_BIT_RX_SLIP];

    // Enable fields; bits 4 and 3 carry none
    wire tx_overflow_irq_en_nxt      = enable_nxt[`SBF_BIT_TX_OVF];
    wire tx_underflow_irq_en_nxt     = enable_nxt[`SBF_BIT_TX_UNF];
    wire tx_slip_irq_en_nxt          = enable_nxt[`SBF_BIT_TX_SLIP];
    wire rx_overflow_irq_en_nxt      = enable_nxt[`SBF_BIT_RX_OVF];
    wire rx_underflow_irq_en_nxt     = enable_nxt[`SBF_BIT_RX_UNF];
    wire rx_slip_irq_en_nxt          = enable_nxt[`SBF_BIT_RX_SLIP];

    // ***************************************************************
    // Interrupt output
    // ***************************************************************

    // Any enabled flag raises the request; pairs are spelled out so
    // each source is masked by its own enable and nothing else.
    // A flag set while its enable is low stays pending for later.
    wire irq_nxt = (tx_store_overflow_flag_nxt  & tx_overflow_irq_en_nxt)
                 | (tx_store_underflow_flag_nxt & tx_underflow_irq_en_nxt)
                 | (tx_store_slip_flag_nxt      & tx_slip_irq_en_nxt)
                 | (rx_store_overflow_flag_nxt  & rx_overflow_irq_en_nxt)
                 | (rx_store_underflow_flag_nxt & rx_underflow_irq_en_nxt)
                 | (rx_store_slip_flag_nxt      & rx_slip_irq_en_nxt);

    // Registered from next-state values so irq tracks the flags
    // with no added cycle of latency.
    always @(posedge sys_clk)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= irq_nxt;
    end

endmodule // sbf_top

//--- tb/sbf_chk_assertions.sv
/* Port checks for the slip event block.
   Assumes binding to sbf_top: one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module sbf_chk (
    // Clock and reset
    input wire        sys_clk,
    input wire        nrst,
    // Register bus
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Store strobes, slip pulses, interrupt
    input wire        rx_wr_stb,
    input wire        rx_rd_stb,
    input wire        tx_wr_stb,
    input wire        tx_rd_stb,
    input wire        rx_frame_delete,
    input wire        rx_frame_repeat,
    input wire        tx_frame_delete,
    input wire        tx_frame_repeat,
    input wire        irq
);
// ***********************************************
// Assertions
// ***********************************************
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
// Accepted access and any slip; irq may trail its cause by one or two edges
wire acc_w  = (avs_read | avs_write) & ~avs_waitrequest;
wire slip_w = rx_frame_delete | rx_frame_repeat | tx_frame_delete | tx_frame_repeat;
AST_RX_DEL: assert property (rx_frame_delete |-> $past(rx_wr_stb) && !$past(rx_rd_stb))
    else $error("rx delete without lone write");
AST_RX_REP: assert property (rx_frame_repeat |-> $past(rx_rd_stb) && !$past(rx_wr_stb))
    else $error("rx repeat without lone read");
AST_TX_DEL: assert property (tx_frame_delete |-> $past(tx_wr_stb) && !$past(tx_rd_stb))
    else $error("tx delete without lone write");
AST_TX_REP: assert property (tx_frame_repeat |-> $past(tx_rd_stb) && !$past(tx_wr_stb))
    else $error("tx repeat without lone read");
AST_ONE_SLIP: assert property ((rx_frame_delete || rx_frame_repeat) |=> !(rx_frame_delete || rx_frame_repeat))
    else $error("rx slip longer than one cycle");
AST_IRQ_RISE: assert property ($rose(irq) |-> $past(slip_w || acc_w) || $past(slip_w, 2))
    else $error("irq rose without cause");
AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc_w) || $past(acc_w, 2))
    else $error("irq fell without access");
AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
AST_RD_HI: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule // sbf_chk

bind sbf_top sbf_chk i_chk (.sys_clk(sys_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_wr_stb(rx_wr_stb),
    .rx_rd_stb(rx_rd_stb), .tx_wr_stb(tx_wr_stb), .tx_rd_stb(tx_rd_stb), .rx_frame_delete(rx_frame_delete),
    .rx_frame_repeat(rx_frame_repeat), .tx_frame_delete(tx_frame_delete), .tx_frame_repeat(tx_frame_repeat),
    .irq(irq));

//--- tb/tb_top.sv
/* Self-checking bench for the slip event block.
   Assumes sbf_top with a shortened frame; checker bound separately. */
`timescale 1ns/1ps
module tb_top;
// ***********************************************
// Stimulus, checks and scenarios
// ***********************************************
localparam FW = 4;
localparam SF = 2;
localparam FULL = FW * SF;
reg          sys_clk = 1'b0;
reg          nrst = 1'b0;
reg  [3:0]   avs_address = 4'h0;
reg          avs_read = 1'b0;
reg          avs_write = 1'b0;
reg  [31:0]  avs_writedata = 32'h0;
reg  [3:0]   stb_r = 4'h0;         // tx_rd, tx_wr, rx_rd, rx_wr
wire [31:0]  avs_readdata;
wire         avs_waitrequest;
wire         irq;
wire [3:0]   slip_w;               // tx_rep, tx_del, rx_rep, rx_del
reg  [7:0]   pc [0:3];
reg  [31:0]  q;
integer      bad_count = 0;
integer      samples_checked = 0;
integer      i;
sbf_top #(.FRAME_WORDS(FW), .STORE_FRAMES(SF), .LVL_W(8)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_wr_stb(stb_r[0]), .rx_rd_stb(stb_r[1]),
    .tx_wr_stb(stb_r[2]), .tx_rd_stb(stb_r[3]), .rx_frame_delete(slip_w[0]), .rx_frame_repeat(slip_w[1]),
    .tx_frame_delete(slip_w[2]), .tx_frame_repeat(slip_w[3]), .irq(irq));
initial forever #4 sys_clk = ~sys_clk;
// Count slip pulses so each event proves exactly one frame action
initial for (i = 0; i < 4; i = i + 1) pc[i] = 8'h0;
always @(posedge sys_clk) for (int k = 0; k < 4; k++) if (slip_w[k] === 1'b1) pc[k] <= pc[k] + 8'h1;
task chk(input [31:0] s, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e)
    begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
endtask
// One bus cycle, held until waitrequest is seen low; result in q.
// No cycle count is assumed: only the watchdog ends a hung wait.
task bus(input wr, input [3:0] a, input [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
        @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task rd(input [3:0] a, input [31:0] e); bus(1'b0, a, 32'h0); chk(q, e); endtask
// Back-to-back strobes, then let flags settle
task strobe(input [3:0] m, input integer n);
    repeat (n) @(posedge sys_clk) stb_r <= m;
    @(posedge sys_clk) stb_r <= 4'h0;
    repeat (2) @(posedge sys_clk);
endtask
task irq_is(input e); repeat (2) @(negedge sys_clk); chk({31'h0, irq}, {31'h0, e}); endtask
task t_regs;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    rd(4'h4, 32'he7);
    bus(1'b1, 4'h8, 32'hff);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'hff);
    rd(4'h0, 32'h0);
    irq_is(1'b0);
    $display("registers done");
endtask
task t_rx;
    bus(1'b1, 4'h4, 32'h0);
    strobe(4'h1, FULL);
    rd(4'h0, 32'h0);
    strobe(4'h1, 1);
    rd(4'h0, 32'h05);
    rd(4'h0, 32'h0);
    strobe(4'h2, FULL - FW + 1);
    rd(4'h0, 32'h0);
    strobe(4'h2, 1);
    rd(4'h0, 32'h03);
    // Drain, then read and write together at empty: no slip
    strobe(4'h2, FW - 1);
    strobe(4'h3, 2);
    rd(4'h0, 32'h0);
    chk({pc[1], pc[0]}, 16'h0101);
    $display("rx slips done");
endtask
task t_tx;
    bus(1'b1, 4'h4, 32'h80);
    strobe(4'h8, 1);
    irq_is(1'b0);
    bus(1'b1, 4'h4, 32'h20);
    irq_is(1'b1);
    bus(1'b1, 4'h4, 32'h40);
    irq_is(1'b1);
    rd(4'h0, 32'h60);
    irq_is(1'b0);
    bus(1'b1, 4'h4, 32'h80);
    strobe(4'h4, FULL - FW + 2);
    irq_is(1'b1);
    rd(4'h0, 32'ha0);
    bus(1'b1, 4'h4, 32'h07);
    strobe(4'h1, FULL + 1);
    irq_is(1'b1);
    bus(1'b1, 4'h4, 32'h0);
    irq_is(1'b0);
    rd(4'h0, 32'h05);
    chk({pc[3], pc[2]}, 16'h0101);
    $display("tx slips and irq done");
endtask
task wrap_up;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
initial
begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_rx;
    t_tx;
    wrap_up;
end
// Watchdog well beyond the fewer than two hundred cycles the tests need
initial
begin
    repeat (5000) @(posedge sys_clk);
    bad_count = bad_count + 1;
    wrap_up;
end
endmodule // tb_top
